/* File: hdl/adc_alert_and_config_regs.sv */
// Result, alert flag and setup registers of the 12-bit converter
// Summary of operation
// - Result register at pointer 0 is read-only, resets zero, bits 14:12 read zero.
// - Result bit 15 shows either alert flag when indicator enabled, else zero.
// - Result bits 11:0 hold the unsigned 12-bit conversion code, MSB bit 11.
// - Alert flags at pointer 1 reset zero; bits 7:2 read zero, written zero.
// - Over-range flag bit 1 sets when result exceeds upper limit.
// - Under-range flag bit 0 sets when result is below lower limit.
// - Writing one clears a flag; writing zero leaves it.
// - Unlatched, over flag clears when result below upper minus hysteresis margin.
// - Unlatched, under flag clears when result above lower plus hysteresis margin.
// - Latched flags never self-clear; only a one write clears them.
// - Setup at pointer 2 resets zero; bit 1 reads zero, written zero.
// - Setup bits 7:5 zero disable auto mode; non-zero starts repeated conversions.
// - Auto interval is conversion period times 32, doubling per code to 2048.
// - Setup bit 4 selects latching; zero allows hysteresis self-clear.
// - Setup bit 3 enables the alert indicator bit 15.
// - Setup bit 2 enables the alert pin; zero leaves it undriven.
// - Setup bit 0 sets alert polarity: zero active low, one active high.
// - First write byte loads the pointer; only low three bits select.
// - A conversion starts on a result read and periodically in auto mode; starts while busy fold into one.
`timescale 1ns/1ps
`include "adc_alert_consts.svh"
module adc_alert_and_config_regs
  import adc_alert_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // Byte requests from the serial engine
  input  wire reg_req_t    req_in,
  output logic [7:0]       rd_hi_out,
  output logic [7:0]       rd_lo_out,
  // Limit registers, also written over the serial engine
  input  wire logic        lim_wr_in,
  input  wire logic [11:0] lim_data_in,
  // Converter handshake
  output logic             conv_start_out,
  input  wire conv_done_t  conv_in,
  // Alert pin
  output logic             alert_o_out,
  output logic             alert_oe_out
);
  typedef enum logic [2:0] {
    IDLE = 3'b001,
    BUSY = 3'b010,
    DONE = 3'b100
  } conv_state_t;

  conv_state_t state;
  conv_state_t next_state;
  logic [2:0]  pointer;
  logic [11:0] result_code;
  logic [1:0]  flags;
  logic [7:0]  setup;
  logic [11:0] lower_limit;
  logic [11:0] upper_limit;
  logic [11:0] hysteresis_margin;
  logic        auto_tick;
  logic        start_req;
  logic        pending;

  wire [1:0]  next_flags;
  wire        over_set;
  wire        under_set;
  wire        over_clr;
  wire        under_clr;
  wire        latched;
  wire        any_flag;
  wire        sel_flags_wr;
  wire        sel_setup_wr;
  wire [15:0] result_word;
  wire [15:0] read_word;
  wire [12:0] over_thresh;
  wire [12:0] under_thresh;
  wire        sel_lower_wr;
  wire        sel_upper_wr;
  wire        sel_hyst_wr;
  wire        at_result;
  wire        at_flags;
  wire        at_setup;
  wire        at_lower;
  wire        at_upper;
  wire        at_hyst;
  wire        launch;
  wire        next_pending;

  function automatic [15:0] pad12(input logic [11:0] v);
    pad12 = {4'h0, v};
  endfunction : pad12

  // One pointer decoder shared by reads and writes keeps them in step
  function automatic logic ptr_is(input logic [2:0] ptr, input logic [2:0] sel);
    ptr_is = (ptr == sel);
  endfunction : ptr_is

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pointer <= `PTR_RESULT;
    else if (req_in.ptr_load)
      pointer <= req_in.data[2:0];
  end

  assign at_result    = ptr_is(pointer, `PTR_RESULT);
  assign at_flags     = ptr_is(pointer, `PTR_FLAGS);
  assign at_setup     = ptr_is(pointer, `PTR_SETUP);
  assign at_lower     = ptr_is(pointer, `PTR_LOWER);
  assign at_upper     = ptr_is(pointer, `PTR_UPPER);
  assign at_hyst      = ptr_is(pointer, `PTR_HYST);
  assign sel_flags_wr = req_in.wr && !req_in.ptr_load && at_flags;
  assign sel_setup_wr = req_in.wr && !req_in.ptr_load && at_setup;
  // Limits arrive on the side port once the pointer byte has picked one
  assign sel_lower_wr = lim_wr_in && at_lower;
  assign sel_upper_wr = lim_wr_in && at_upper;
  assign sel_hyst_wr  = lim_wr_in && at_hyst;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      setup <= `SETUP_RESET;
    else if (sel_setup_wr)
      setup <= req_in.data & `SETUP_WMASK;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      lower_limit <= `LOWER_RESET;
    else if (sel_lower_wr)
      lower_limit <= lim_data_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      upper_limit <= `UPPER_RESET;
    else if (sel_upper_wr)
      upper_limit <= lim_data_in;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      hysteresis_margin <= `HYST_RESET;
    else if (sel_hyst_wr)
      hysteresis_margin <= lim_data_in;
  end

  // interval timer runs only for non-zero code
  conv_timer u_timer (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .cycle_code_in (setup[`CYC_HI:`CYC_LO]),
    .tick_out      (auto_tick)
  );

  // result read or auto tick starts a conversion
  assign start_req = (req_in.rd && !req_in.ptr_load && at_result) || auto_tick;

  // Starts that arrive while busy fold into one pending conversion
  assign launch       = (state == IDLE) && (start_req || pending);
  assign next_pending = (state != IDLE) && (pending || start_req);

  always_comb
  begin
    next_state = state;
    case (state)
      IDLE:
      begin
        if (launch)
          next_state = BUSY;
      end
      BUSY:
      begin
        if (conv_in.valid)
          next_state = DONE;
      end
      DONE:
      begin
        next_state = IDLE;
      end
      default:
      begin
        next_state = IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state <= IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      pending <= 1'b0;
    else
      pending <= next_pending;
  end

  // Registered so the analog side sees a clean one-cycle start
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      conv_start_out <= 1'b0;
    else
      conv_start_out <= launch;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      result_code <= 12'(`RESULT_RESET);
    else if (state == BUSY && conv_in.valid)
      result_code <= conv_in.code;
  end

  assign over_set  = (state == DONE) && (result_code > upper_limit);
  assign under_set = (state == DONE) && (result_code < lower_limit);
  // Wide sums so a margin near full scale cannot wrap around
  assign over_thresh  = {1'b0, upper_limit} - {1'b0, hysteresis_margin};
  assign under_thresh = {1'b0, lower_limit} + {1'b0, hysteresis_margin};
  assign latched   = setup[`BIT_HOLD];
  // over self-clear below upper minus margin
  assign over_clr  = (state == DONE) && !latched && !over_thresh[12]
                     && ({1'b0, result_code} < over_thresh);
  // under self-clear above lower plus margin
  assign under_clr = (state == DONE) && !latched && ({1'b0, result_code} > under_thresh);

  // write one clears, set wins over clear
  // latched flags clear only by write
  assign next_flags[`BIT_OVER]  = over_set ||
    (flags[`BIT_OVER] && !over_clr && !(sel_flags_wr && req_in.data[`BIT_OVER]));
  assign next_flags[`BIT_UNDER] = under_set ||
    (flags[`BIT_UNDER] && !under_clr && !(sel_flags_wr && req_in.data[`BIT_UNDER]));

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      flags <= 2'(`FLAGS_RESET & `FLAGS_WMASK);
    else
      flags <= next_flags;
  end

  assign any_flag = |flags;
  assign result_word = {any_flag && setup[`BIT_IND_EN], 3'h0, result_code};
  // Pointers 6 and 7 read zero; no minimum or maximum is kept
  // flags reserved bits read zero
  assign read_word = at_result ? result_word :
                     at_flags  ? {14'h0, flags} :
                     at_setup  ? {8'h00, setup} :
                     at_lower  ? pad12(lower_limit) :
                     at_upper  ? pad12(upper_limit) :
                     at_hyst   ? pad12(hysteresis_margin) : 16'h0000;

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rd_hi_out <= 8'h00;
      rd_lo_out <= 8'h00;
    end
    else
    begin
      rd_hi_out <= read_word[15:8];
      rd_lo_out <= read_word[7:0];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      alert_o_out  <= 1'b0;
      alert_oe_out <= 1'b0;
    end
    else
    begin
      alert_oe_out <= setup[`BIT_PIN_EN];
      alert_o_out  <= any_flag ~^ setup[`BIT_POL];
    end
  end
endmodule : adc_alert_and_config_regs

/* File: hdl/adc_alert_consts.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ADC_ALERT_CONSTS_SVH
`define ADC_ALERT_CONSTS_SVH
`define PTR_RESULT        3'h0
`define PTR_FLAGS         3'h1
`define PTR_SETUP         3'h2
`define PTR_LOWER         3'h3
`define PTR_UPPER         3'h4
`define PTR_HYST          3'h5
`define RESULT_RESET      16'h0000
`define FLAGS_RESET       8'h00
`define SETUP_RESET       8'h00
`define LOWER_RESET       12'h000
`define UPPER_RESET       12'hFFF
`define HYST_RESET        12'h000
`define BIT_OVER          1
`define BIT_UNDER         0
`define BIT_HOLD          4
`define BIT_IND_EN        3
`define BIT_PIN_EN        2
`define BIT_RSVD          1
`define BIT_POL           0
`define CYC_HI            7
`define CYC_LO            5
`define SETUP_WMASK       8'hFD
`define FLAGS_WMASK       8'h03
// Conversion period in ns and its cycle count at the 40 ns clock (round up)
`define T_CONVERT_NS      1000
`define CLK_PERIOD_NS     40
`define CONV_CYCLES       ((`T_CONVERT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BASE_MULT_LOG2    5
`endif

/* File: hdl/adc_alert_pkg.sv */
// Types shared by the alert and configuration register block
package adc_alert_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       ptr_load;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [11:0] code;
  } conv_done_t;
endpackage : adc_alert_pkg

/* File: hdl/conv_timer.sv */
// Automatic conversion interval timer
`timescale 1ns/1ps
`include "adc_alert_consts.svh"
module conv_timer
  import adc_alert_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Interval select from the setup register
  input  wire logic [2:0] cycle_code_in,
  // One-cycle start request
  output logic            tick_out
);
  logic [21:0] count;
  logic [21:0] limit;
  logic        enabled;

  assign enabled = (cycle_code_in != 3'h0);
  assign limit = 22'((`CONV_CYCLES) << (`BASE_MULT_LOG2 + cycle_code_in - 1)) - 22'h1;

  always_ff @(posedge clock_in)
  begin
    if (rst_in || !enabled)
    begin
      count    <= 22'h0;
      tick_out <= 1'b0;
    end
    else if (count >= limit)
    begin
      count    <= 22'h0;
      tick_out <= 1'b1;
    end
    else
    begin
      count    <= count + 22'h1;
      tick_out <= 1'b0;
    end
  end
endmodule : conv_timer

/* File: verification/alert_regs_sva.sv */
// Port checker for the alert and setup registers
`timescale 1ns/1ps
module alert_regs_sva
  import adc_alert_pkg::*;
(
  // Clock and reset
  input wire logic       clock_in,
  input wire logic       rst_in,
  // Register side
  input wire reg_req_t   req_in,
  input wire logic [7:0] rd_hi_out,
  input wire logic [7:0] rd_lo_out,
  // Converter and pin
  input wire logic       conv_start_out,
  input wire conv_done_t conv_in,
  input wire logic       alert_o_out,
  input wire logic       alert_oe_out
);
  logic [2:0]  ptr;
  logic [7:0]  setup;
  logic [11:0] gap;
  logic [2:0]  quiet;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Shadows of pointer and setup writes; gap counts cycles since a start or write, quiet since a result
  always_ff @(posedge clock_in)
  begin
    ptr <= rst_in ? 3'h0 : req_in.ptr_load ? req_in.data[2:0] : ptr;
    setup <= rst_in ? 8'h00 : (req_in.wr && ptr == 3'h2) ? req_in.data & 8'hFD : setup;
    gap <= (rst_in || conv_start_out || req_in.wr) ? 12'h000 : gap + {11'h000, gap != 12'hFFF};
    quiet <= (rst_in || conv_in.valid) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  end
  property p_rsvd; rd_hi_out[6:4] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("spare result bits set");
  property p_ind; $past(ptr) == 3'h0 && !$past(setup[3]) |-> !rd_hi_out[7]; endproperty
  a_ind: assert property (p_ind) else $error("indicator not masked");
  property p_flags; $past(ptr) == 3'h1 |-> {rd_hi_out, rd_lo_out[7:2]} == 14'h0000; endproperty
  a_flags: assert property (p_flags) else $error("spare flag bits set");
  property p_setup; $past(ptr) == 3'h2 |-> {rd_hi_out, rd_lo_out} == {8'h00, $past(setup)}; endproperty
  a_setup: assert property (p_setup) else $error("setup readback wrong");
  property p_oe; alert_oe_out == $past(setup[2]); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_pol; $past(setup[0]) != $past(setup[0], 2) && quiet == 3'h7 |-> alert_o_out != $past(alert_o_out); endproperty
  a_pol: assert property (p_pol) else $error("polarity not applied");
  property p_start; req_in.rd && ptr == 3'h0 && gap > 12'h010 |=> conv_start_out; endproperty
  a_start: assert property (p_start) else $error("read started nothing");
  // Startup of the timer may add a few cycles
  property p_auto; setup[7:5] == 3'h1 |-> gap < 12'h32A; endproperty
  a_auto: assert property (p_auto) else $error("auto interval too long");
  c_auto: cover property (conv_start_out && setup[7:5] != 3'h0);
  c_alert: cover property (alert_oe_out && !alert_o_out);
  c_clear: cover property (req_in.wr && ptr == 3'h1 && req_in.data[0]);
endmodule : alert_regs_sva
bind adc_alert_and_config_regs alert_regs_sva alert_regs_sva_i (.clock_in, .rst_in, .req_in, .rd_hi_out,
  .rd_lo_out, .conv_start_out, .conv_in, .alert_o_out, .alert_oe_out);

/* File: verification/analog_core_model.sv */
// Behavioural analog core answering start pulses
`timescale 1ns/1ps
module analog_core_model
  import adc_alert_pkg::*;
(
  // Clock
  input  wire logic        clock_in,
  // Start and code to return
  input  wire logic        start_in,
  input  wire logic [11:0] code_in,
  // Completion
  output conv_done_t       done_out
);
  logic [1:0] cnt = 2'h0;
  initial done_out = '0;
  always @(posedge clock_in)
  begin
    cnt <= start_in ? 2'h3 : cnt - {1'b0, cnt != 2'h0};
    done_out.valid <= cnt == 2'h1;
    // plain binary code; idle cycles carry a changing pattern
    done_out.code <= (cnt == 2'h1) ? code_in : ~done_out.code;
  end
endmodule : analog_core_model

/* File: verification/tb_adc_alert_and_config_regs.sv */
// Self-checking bench for the alert and setup registers
`timescale 1ns/1ps
module tb_adc_alert_and_config_regs
  import adc_alert_pkg::*;
;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  reg_req_t    req = '0;
  logic        lim_wr = 1'b0;
  logic [11:0] lim_data = 12'h000;
  logic [11:0] code = 12'h000;
  logic [7:0]  hi;
  logic [7:0]  lo;
  logic        start;
  logic        a_o;
  logic        a_oe;
  conv_done_t  done;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          n;
  always #20 clock_in = ~clock_in;
  adc_alert_and_config_regs adc_alert_and_config_regs_i (.clock_in, .rst_in, .req_in(req), .rd_hi_out(hi),
    .rd_lo_out(lo), .lim_wr_in(lim_wr), .lim_data_in(lim_data), .conv_start_out(start), .conv_in(done),
    .alert_o_out(a_o), .alert_oe_out(a_oe));
  analog_core_model analog_core_model_i (.clock_in, .start_in(start), .code_in(code), .done_out(done));
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input logic [10:0] r);
    @(negedge clock_in);
    req = r;
    @(negedge clock_in);
    req = '0;
  endtask : cyc
  task automatic wr(input logic [2:0] p, input logic [7:0] d);
    cyc({3'h1, 5'h00, p});
    cyc({3'h4, d});
  endtask : wr
  task automatic look(input logic [2:0] p, input logic [15:0] exp);
    cyc({3'h1, 5'h00, p});
    @(negedge clock_in);
    chk({hi, lo}, exp);
  endtask : look
  task automatic lim(input logic [2:0] p, input logic [11:0] v);
    cyc({3'h1, 5'h00, p});
    lim_wr = 1'b1;
    lim_data = v;
    @(negedge clock_in);
    lim_wr = 1'b0;
  endtask : lim
  task automatic conv(input logic [11:0] c);
    code = c;
    cyc({3'h1, 8'h00});
    cyc({3'h2, 8'h00});
    repeat (12) @(negedge clock_in);
  endtask : conv
  task automatic gap(output int k);
    k = 0;
    do
    begin
      @(negedge clock_in);
      k++;
    end
    while (start !== 1'b1 && k < 4000);
  endtask : gap
  task automatic t_setup;
    look(3'h0, 16'h0000);
    look(3'h1, 16'h0000);
    wr(3'h2, 8'hFD);
    look(3'h2, 16'h00FD);
    chk({14'h0000, a_oe, a_o}, 16'h0002);
    wr(3'h2, 8'h0C);
    // Pins follow the setup register one cycle later
    @(negedge clock_in);
    chk({14'h0000, a_oe, a_o}, 16'h0003);
  endtask : t_setup
  task automatic t_over;
    lim(3'h4, 12'h800);
    lim(3'h5, 12'h020);
    conv(12'h801);
    look(3'h0, 16'h8801);
    chk({15'h0000, a_o}, 16'h0000);
    conv(12'h7E0);
    look(3'h1, 16'h0002);
    conv(12'h7DF);
    look(3'h1, 16'h0000);
    look(3'h0, 16'h07DF);
  endtask : t_over
  task automatic t_under;
    lim(3'h4, 12'hFFF);
    lim(3'h3, 12'h100);
    conv(12'h0FF);
    look(3'h1, 16'h0001);
    conv(12'h120);
    wr(3'h1, 8'h00);
    look(3'h1, 16'h0001);
    conv(12'h121);
    look(3'h1, 16'h0000);
    conv(12'h0FF);
    wr(3'h1, 8'h01);
    look(3'h1, 16'h0000);
  endtask : t_under
  task automatic t_hold;
    wr(3'h2, 8'h18);
    conv(12'h0FF);
    conv(12'h800);
    look(3'h1, 16'h0001);
    look(3'h0, 16'h8800);
    chk({15'h0000, a_oe}, 16'h0000);
    wr(3'h2, 8'h10);
    look(3'h0, 16'h0800);
    wr(3'h1, 8'h01);
  endtask : t_hold
  task automatic t_auto;
    for (int c = 1; c < 4; c++)
    begin
      wr(3'h2, {c[2:0], 5'h00});
      gap(n);
      gap(n);
      chk(n[15:0], 16'h0320 << (c - 1));
    end
    wr(3'h2, 8'h00);
    gap(n);
    chk(n[15:0], 16'h0FA0);
  endtask : t_auto
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (20) @(negedge clock_in);
    rst_in = 1'b0;
    t_setup();
    t_over();
    t_under();
    t_hold();
    t_auto();
    results();
  end
endmodule : tb_adc_alert_and_config_regs
